// ---- bench/per_host_model.sv ----
`timescale 1ns/100ps
module per_host_model #(
    parameter int HALF = 8
) (
    input  wire logic clk,
    output logic      sen,
    output logic      sclk,
    output logic      sdi,
    input  wire logic sdo,
    input  wire logic sdo_oe
);
    initial begin
        sen  = 1'b0;
        sclk = 1'b0;
        sdi  = 1'b0;
    end

    // The clock idles low outside frames and a released data line flips.
    task automatic frame(input logic [30:0] bits, input int n,
                         output logic [23:0] rd, output logic oe_ok);
        rd = '0;
        oe_ok = 1'b1;
        @(negedge clk);
        sen <= 1'b1;
        for (int i = 0; i < n; i++) begin
            sdi  <= (i < 31) ? bits[30-i] : 1'b0;
            sclk <= 1'b0;
            repeat (HALF) @(negedge clk);
            sclk <= 1'b1;
            repeat (HALF) @(negedge clk);
            if (i >= 7 && i < 31) begin
                rd = {rd[22:0], sdo};
                oe_ok = oe_ok & (sdo_oe === 1'b1);
            end
        end
        sclk <= 1'b0;
        repeat (HALF) @(negedge clk);
        sen <= 1'b0;
        sdi <= ~sdi;
        repeat (HALF) @(negedge clk);
    endtask
endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/100ps
module tb_top
    import per_pkg::*;
;
    logic        clk;
    logic        nrst;
    logic        sen;
    logic        sclk;
    logic        sdi;
    logic        sdo;
    logic        sdo_oe;
    logic        ss;
    logic        cse;
    logic        im;
    per_ctrl_t   ctrl;
    per_strobe_t strobe;
    logic [15:0] enr;
    logic [7:0]  stb_hi [4] = '{default: 8'h00};
    int          err_total = 0;
    int          checks_done = 0;
    int          cyc = 0;

    per_ctrl_regs DUT (.clk(clk), .nrst(nrst), .sen(sen), .sclk(sclk),
        .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .sine_ref_select(ss),
        .slip_feature_enable(cse), .integer_mode(im), .ctrl(ctrl),
        .strobe(strobe), .enable_and_reset_control(enr));

    per_host_model host (.clk(clk), .sen(sen), .sclk(sclk), .sdi(sdi),
        .sdo(sdo), .sdo_oe(sdo_oe));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        for (int j = 0; j < 4; j++) begin
            if (strobe[j] === 1'b1) begin
                stb_hi[j] <= stb_hi[j] + 8'h01;
            end
        end
    end

    task automatic tally_and_finish();
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic per_ctrl_t exp_ctrl(input logic [15:0] r);
        logic b;
        b = r[1];
        return {r[0], b, r[2] & b, r[3], r[4], r[5], r[6], r[7] & ~ss,
                r[8] & ss, r[9], r[10] & b, r[11] & b, r[12] & b,
                r[13] & b & ~im, r[14] & b, r[15] & cse & b};
    endfunction

    task automatic wr(input logic [5:0] a, input logic [23:0] d);
        logic [23:0] r;
        logic        o;
        host.frame({1'b0, a, d}, 32, r, o);
    endtask

    task automatic rd(input logic [5:0] a, input logic [23:0] exp);
        logic [23:0] r;
        logic        o;
        host.frame({1'b1, a, 24'h00_0000}, 32, r, o);
        chk(r, exp);
        chk({23'h0, o}, 24'h00_0001);
        chk({23'h0, sdo_oe}, 24'h00_0000);
    endtask

    task automatic t_defaults();
        chk({8'h00, enr}, {8'h00, ENABLE_RESET});
        chk({8'h00, ctrl}, {8'h00, exp_ctrl(ENABLE_RESET)});
        chk({20'h0, strobe}, 24'h00_0000);
        rd(OFF_STROBE_ID, CHIP_ID_DEFAULT);
        rd(6'h05, 24'h00_0000);
        rd(OFF_ENABLE, {8'h00, ENABLE_RESET});
    endtask

    // Each bit alone cleared, then alone set, so bias gating is exercised.
    task automatic t_enable_bits();
        logic [15:0] v;
        for (int k = 0; k < 32; k++) begin
            v = (k < 16) ? ~(16'h0001 << k) : (16'h0001 << (k - 16));
            wr(OFF_ENABLE, {8'hA5, v});
            chk({8'h00, enr}, {8'h00, v});
            chk({8'h00, ctrl}, {8'h00, exp_ctrl(v)});
            rd(OFF_ENABLE, {8'h00, v});
        end
    endtask

    task automatic t_side_inputs();
        wr(OFF_ENABLE, 24'h00_FFFF);
        for (int c = 0; c < 8; c++) begin
            @(negedge clk);
            {ss, cse, im} = c[2:0];
            repeat (3) @(negedge clk);
            chk({8'h00, ctrl}, {8'h00, exp_ctrl(16'hFFFF)});
            chk({8'h00, ctrl}, {8'h00, exp_ctrl(16'hFFFF)});
        end
        {ss, cse, im} = 3'b010;
    endtask

    // Strobe bit 0 goes last, since it restores the enable register.
    task automatic t_strobes();
        logic [7:0]  s [4];
        logic [23:0] d;
        wr(OFF_ENABLE, 24'h00_0000);
        for (int k = 4; k >= 0; k--) begin
            s = stb_hi;
            d = (k == 4) ? 24'h00_0000 : 24'hFF_FFF0 | (24'h00_0001 << k);
            wr(OFF_STROBE_ID, d);
            for (int j = 0; j < 4; j++) begin
                d = {16'h0000, stb_hi[3-j] - s[3-j]};
                chk(d, {23'h0, j == k});
            end
            d = (k == 0) ? {8'h00, ENABLE_RESET} : 24'h00_0000;
            chk({8'h00, enr}, d);
        end
        chk({8'h00, ctrl}, {8'h00, exp_ctrl(ENABLE_RESET)});
    endtask

    task automatic t_refused();
        logic [23:0] r;
        logic        o;
        wr(OFF_ENABLE, 24'h00_1111);
        host.frame({1'b0, OFF_ENABLE, 24'h00_2222}, 20, r, o);
        chk({8'h00, enr}, 24'h00_1111);
        wr(6'h02, 24'h00_3333);
        chk({8'h00, enr}, 24'h00_1111);
    endtask

    task automatic t_mid_reset();
        wr(OFF_ENABLE, 24'h00_0000);
        nrst = 1'b0;
        repeat (2) @(negedge clk);
        chk({8'h00, enr}, {8'h00, ENABLE_RESET});
        chk({8'h00, ctrl}, 24'h00_0000);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        chk({8'h00, ctrl}, {8'h00, exp_ctrl(ENABLE_RESET)});
        rd(OFF_ENABLE, {8'h00, ENABLE_RESET});
    endtask

    initial begin
        nrst = 1'b0;
        {ss, cse, im} = 3'b010;
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        t_defaults();
        t_enable_bits();
        t_side_inputs();
        t_strobes();
        t_refused();
        t_mid_reset();
        tally_and_finish();
    end
endmodule

// ---- hdl/per_ctrl_regs.sv ----
`timescale 1ns/100ps
// Notes on behaviour
// - A one in strobe bit 1 pulses soft reset of other digital logic.
// - Writing one to strobe bit 3 clocks one temperature measurement.
// - Enable bit 1 zero disables the whole loop; default one.
// - Bit 2 zero holds ref divider in reset, like bypass; default zero.
// - Bit 3 gates muxed crystal reference to digital; default one.
// - Bit 4 enables divided reference clock to digital; default one.
// - Bit 5 enables square crystal clock to main digital; default zero.
// - Bit 6 enables sine crystal clock to main digital; default zero.
// - Bit 7 square buffer, only while sine select is zero; default one.
// - Bit 8 sine buffer, only while sine select is one; default zero.
// - Bit 9 modulator clock: one oscillator, zero reference; default one.
// - Bit 10 enables prescaler bias; default one.
// - Bit 11 low resets the lock detect output gates; default one.
// - Bit 12 enables charge pump, zero floats its output; default one.
// - Bit 13 active-low modulator reset, combined with integer mode.
// - Bit 14 active-low lock detect reset; default one.
// - Bit 15 releases cycle slip flops only with external enable set.
// - A one in strobe bit 0 returns configuration registers to defaults.
// - Sine select bit gates the two reference buffers.
module per_ctrl_regs
    import per_pkg::*;
#(
    parameter logic [23:0] CHIP_ID = CHIP_ID_DEFAULT
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        sen,
    input  wire logic        sclk,
    input  wire logic        sdi,
    output logic             sdo,
    output logic             sdo_oe,
    input  wire logic        sine_ref_select,
    input  wire logic        slip_feature_enable,
    input  wire logic        integer_mode,
    output per_ctrl_t        ctrl,
    output per_strobe_t      strobe,
    output logic [15:0]      enable_and_reset_control
);

    default clocking cb_chk @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // Pin synchronisers: three stages, a change on sen or sclk counts once stages
    // 2 and 3 agree.
    logic [2:0] sen_sync;
    logic [2:0] sclk_sync;
    logic [2:0] sdi_sync;
    logic       sen_q;
    logic       sclk_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sen_sync  <= 3'h0;
            sclk_sync <= 3'h0;
            sdi_sync  <= 3'h0;
        end else begin
            sen_sync  <= {sen_sync[1:0], sen};
            sclk_sync <= {sclk_sync[1:0], sclk};
            sdi_sync  <= {sdi_sync[1:0], sdi};
        end
    end

    wire sen_agree  = sen_sync[1] == sen_sync[2];
    wire sclk_agree = sclk_sync[1] == sclk_sync[2];
    wire next_sen   = sen_agree ? sen_sync[2] : sen_q;
    wire next_sclk  = sclk_agree ? sclk_sync[2] : sclk_q;
    wire sclk_rise  = next_sclk && !sclk_q && sen_q;
    wire sdi_bit    = sdi_sync[2];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sen_q  <= 1'b0;
            sclk_q <= 1'b0;
        end else begin
            sen_q  <= next_sen;
            sclk_q <= next_sclk;
        end
    end

    // Frame decoder.
    per_state_t        state;
    per_state_t        next_state;
    logic [4:0]        cnt;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] shreg;
    logic [15:0]       en_reg;

    wire cnt_addr_end = cnt == 5'(ADDR_LAST);
    wire cnt_last     = cnt == 5'(FRAME_LAST);
    wire [DATA_W-1:0] wr_word = {shreg[DATA_W-2:0], sdi_bit};
    wire wr_commit    = state == PER_WRITE && sclk_rise && cnt_last;
    wire hit_strobe   = addr == OFF_STROBE_ID;
    wire hit_enable   = addr == OFF_ENABLE;
    wire rd_start     = state == PER_ADDR && sclk_rise && cnt_addr_end;
    wire [ADDR_W-1:0] rd_addr = {addr[ADDR_W-2:0], sdi_bit};
    // Unmapped addresses read as zero.
    wire [DATA_W-1:0] rd_word =
        (rd_addr == OFF_STROBE_ID) ? CHIP_ID :
        (rd_addr == OFF_ENABLE)    ? {8'h00, en_reg} : 24'h00_0000;

    logic rd_flag;

    always_comb begin
        next_state = state;
        case (state)
            PER_IDLE:  if (sclk_rise) next_state = PER_ADDR;
            PER_ADDR:  if (sclk_rise && cnt_addr_end) begin
                next_state = rd_flag ? PER_READ : PER_WRITE;
            end
            PER_WRITE: if (sclk_rise && cnt_last) next_state = PER_DONE;
            PER_READ:  if (sclk_rise && cnt_last) next_state = PER_DONE;
            PER_DONE:  next_state = PER_DONE;
            default:   next_state = PER_IDLE;
        endcase
        if (!sen_q) begin
            next_state = PER_IDLE;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state   <= PER_IDLE;
            cnt     <= 5'h00;
            rd_flag <= 1'b0;
            addr    <= '0;
            shreg   <= '0;
        end else begin
            state <= next_state;
            if (!sen_q) begin
                cnt <= 5'h00;
            end else if (sclk_rise) begin
                cnt <= cnt + 5'h01;
            end
            if (state == PER_IDLE && sclk_rise) begin
                rd_flag <= sdi_bit;
            end
            if (state == PER_ADDR && sclk_rise) begin
                addr <= rd_addr;
            end
            if (rd_start) begin
                shreg <= rd_word;
            end else if (state == PER_READ && sclk_rise) begin
                shreg <= {shreg[DATA_W-2:0], 1'b0};
            end else if (state == PER_WRITE && sclk_rise) begin
                shreg <= wr_word;
            end
        end
    end

    // Read data leaves MSB first, one bit per rising serial clock.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sdo    <= 1'b0;
            sdo_oe <= 1'b0;
        end else begin
            // Hold the pin driven until the host drops the enable, so the
            // last bit is still there at its falling serial edge.
            sdo_oe <= next_state == PER_READ
                   || (next_state == PER_DONE && sdo_oe);
            if (state == PER_READ && sclk_rise) begin
                sdo <= shreg[DATA_W-1];
            end else if (!sen_q) begin
                sdo <= 1'b0;
            end
        end
    end

    // Strobes hold no state: each written one gives exactly one pulse.
    wire         stb_hit = wr_commit && hit_strobe;
    per_strobe_t next_strobe;
    assign next_strobe.regs_soft_reset =
        stb_hit && wr_word[STB_REGS_RST];
    assign next_strobe.dig_soft_reset  =
        stb_hit && wr_word[STB_DIG_RST];
    assign next_strobe.resync          =
        stb_hit && wr_word[STB_RESYNC];
    assign next_strobe.temp_measure    =
        stb_hit && wr_word[STB_TEMP];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strobe <= '0;
        end else begin
            strobe <= next_strobe;
        end
    end

    // Enable register: written by frame, restored by the register strobe.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            en_reg <= ENABLE_RESET;
        end else if (strobe.regs_soft_reset) begin
            en_reg <= ENABLE_RESET;
        end else if (wr_commit && hit_enable) begin
            en_reg <= wr_word[15:0];
        end
    end

    // Bias off takes the whole loop down with it.
    wire       loop_on = en_reg[EN_BIAS];
    per_ctrl_t next_ctrl;
    assign next_ctrl.osc_buf_on      = en_reg[EN_OSC_BUF];
    assign next_ctrl.bias_on         = loop_on;
    assign next_ctrl.refdiv_run      = loop_on && en_reg[EN_REFDIV];
    assign next_ctrl.xref_to_dig     = en_reg[EN_XREF_DIG];
    assign next_ctrl.divref_to_dig   = en_reg[EN_DIVREF_DIG];
    assign next_ctrl.sq_xtal_to_dig  = en_reg[EN_SQ_DIG];
    assign next_ctrl.sin_xtal_to_dig = en_reg[EN_SIN_DIG];
    assign next_ctrl.square_ref_buffer_on =
        en_reg[EN_SQ_BUF] && !sine_ref_select;
    assign next_ctrl.sine_ref_buffer_on =
        en_reg[EN_SIN_BUF] && sine_ref_select;
    assign next_ctrl.mod_clk_from_osc = en_reg[EN_MOD_CLK_OSC];
    assign next_ctrl.prescaler_on    = loop_on && en_reg[EN_PRESC];
    assign next_ctrl.lock_gates_run  =
        loop_on && en_reg[EN_LOCK_GATES];
    // The pad driver floats the pump output while this is low.
    assign next_ctrl.charge_pump_on  = loop_on && en_reg[EN_CP];
    assign next_ctrl.modulator_run   =
        loop_on && en_reg[EN_MOD_RUN] && !integer_mode;
    assign next_ctrl.lock_detect_run =
        loop_on && en_reg[EN_LOCK_RUN];
    assign next_ctrl.cycle_slip_prevention =
        loop_on && en_reg[EN_SLIP] && slip_feature_enable;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl                     <= '0;
            enable_and_reset_control <= ENABLE_RESET;
        end else begin
            ctrl                     <= next_ctrl;
            enable_and_reset_control <= en_reg;
        end
    end

    // Checks.
    a_temp_strobe_one: assert property (
        strobe.temp_measure |=> !strobe.temp_measure)
        else $error("temperature strobe longer than one cycle");
    a_temp_cause: assert property (
        $rose(strobe.temp_measure) |-> $past(stb_hit)
            && $past(wr_word[STB_TEMP]))
        else $error("temperature strobe without a written one");
    a_dig_rst_cause: assert property (
        $rose(strobe.dig_soft_reset) |-> $past(stb_hit)
            && $past(wr_word[STB_DIG_RST]))
        else $error("digital soft reset without a written one");
    a_dig_rst_one: assert property (
        strobe.dig_soft_reset |=> !strobe.dig_soft_reset)
        else $error("digital soft reset longer than one cycle");
    a_strobe_zero_quiet: assert property (
        (stb_hit && !wr_word[STB_TEMP]) |=> !strobe.temp_measure)
        else $error("strobe fired on a written zero");
    a_resync_one: assert property (
        strobe.resync |=> !strobe.resync)
        else $error("reserved strobe longer than one cycle");
    a_regs_rst_one: assert property (
        strobe.regs_soft_reset |=> !strobe.regs_soft_reset)
        else $error("register soft reset longer than one cycle");
    a_regs_rst_default: assert property (
        strobe.regs_soft_reset |=> ##1
            enable_and_reset_control == ENABLE_RESET)
        else $error("register soft reset missed the enable register");
    a_bias_kills_loop: assert property (
        !en_reg[EN_BIAS] |=> !ctrl.charge_pump_on && !ctrl.modulator_run
            && !ctrl.prescaler_on && !ctrl.bias_on)
        else $error("loop active with bias off");
    a_sq_buffer_gate: assert property (
        ctrl.square_ref_buffer_on |-> $past(!sine_ref_select)
            && enable_and_reset_control[EN_SQ_BUF])
        else $error("square buffer on while sine selected");
    a_sin_buffer_gate: assert property (
        ctrl.sine_ref_buffer_on |-> $past(sine_ref_select)
            && enable_and_reset_control[EN_SIN_BUF])
        else $error("sine buffer on while square selected");
    a_slip_needs_both: assert property (
        ctrl.cycle_slip_prevention |-> $past(slip_feature_enable)
            && enable_and_reset_control[EN_SLIP])
        else $error("cycle slip flops released without enable");
    a_cp_follows_bit: assert property (
        (en_reg[EN_BIAS] && !en_reg[EN_CP]) |=> !ctrl.charge_pump_on)
        else $error("charge pump on with its bit clear");
    a_cp_runs: assert property (
        (en_reg[EN_BIAS] && en_reg[EN_CP]) |=> ctrl.charge_pump_on)
        else $error("charge pump off with its bit set");
    a_mod_reset_hold: assert property (
        (!en_reg[EN_MOD_RUN] || integer_mode) |=> !ctrl.modulator_run)
        else $error("modulator running while held in reset");
    a_refdiv_hold: assert property (
        !en_reg[EN_REFDIV] |=> !ctrl.refdiv_run)
        else $error("reference divider running with bit clear");
    a_refdiv_runs: assert property (
        (en_reg[EN_BIAS] && en_reg[EN_REFDIV]) |=> ctrl.refdiv_run)
        else $error("reference divider held with bit set");
    a_lock_reset: assert property (
        !en_reg[EN_LOCK_RUN] |=> !ctrl.lock_detect_run)
        else $error("lock detect running with bit clear");
    a_enable_write: assert property (
        (wr_commit && hit_enable) |=> ##1
            enable_and_reset_control == $past(wr_word[15:0], 2))
        else $error("enable register write lost");

    // Each output below follows its register bit one cycle later, gated by bias or sine select where the logic gates it.
    a_osc_buf_follow: assert property (
        1'b1 |=> ctrl.osc_buf_on == $past(en_reg[EN_OSC_BUF]))
        else $error("oscillator buffer enable does not follow its bit");
    a_bias_follow: assert property (
        1'b1 |=> ctrl.bias_on == $past(en_reg[EN_BIAS]))
        else $error("bias enable does not follow its bit");
    a_xref_follow: assert property (
        1'b1 |=> ctrl.xref_to_dig == $past(en_reg[EN_XREF_DIG]))
        else $error("crystal reference gate does not follow its bit");
    a_divref_follow: assert property (
        1'b1 |=> ctrl.divref_to_dig == $past(en_reg[EN_DIVREF_DIG]))
        else $error("divided reference gate does not follow its bit");
    a_sq_dig_follow: assert property (
        1'b1 |=> ctrl.sq_xtal_to_dig == $past(en_reg[EN_SQ_DIG]))
        else $error("square crystal gate does not follow its bit");
    a_sin_dig_follow: assert property (
        1'b1 |=> ctrl.sin_xtal_to_dig == $past(en_reg[EN_SIN_DIG]))
        else $error("sine crystal gate does not follow its bit");
    a_sine_select_gate: assert property (
        1'b1 |=> ctrl.sine_ref_buffer_on
            == $past(en_reg[EN_SIN_BUF] && sine_ref_select))
        else $error("sine buffer does not follow bit and select");
    a_mod_clk_pick: assert property (
        1'b1 |=> ctrl.mod_clk_from_osc == $past(en_reg[EN_MOD_CLK_OSC]))
        else $error("modulator clock choice does not follow its bit");
    a_presc_follow: assert property (
        1'b1 |=> ctrl.prescaler_on
            == $past(en_reg[EN_PRESC] && en_reg[EN_BIAS]))
        else $error("prescaler bias does not follow its bit");
    a_lock_gates_follow: assert property (
        1'b1 |=> ctrl.lock_gates_run
            == $past(en_reg[EN_LOCK_GATES] && en_reg[EN_BIAS]))
        else $error("lock detect gates do not follow their bit");

    c_enable_write: cover property (
        wr_commit && hit_enable);
    c_temp_strobe: cover property (
        strobe.temp_measure);
    c_regs_reset: cover property (
        strobe.regs_soft_reset);
    c_read_frame: cover property (
        state == PER_READ ##[1:1000] state == PER_DONE);
    c_bias_off: cover property (
        !ctrl.bias_on && ctrl.osc_buf_on);

endmodule

// ---- hdl/per_pkg.sv ----
package per_pkg;

    // Serial frame layout: one read/write flag, six address bits, 24 data.
    localparam int ADDR_W       = 6;
    localparam int DATA_W       = 24;
    localparam int FRAME_LAST   = 30;
    localparam int ADDR_LAST    = 6;
    localparam logic [4:0] CNT_W_UNUSED = 5'h00;

    localparam logic [5:0] OFF_STROBE_ID = 6'h00;
    localparam logic [5:0] OFF_ENABLE    = 6'h01;

    // Identification word; the value is arbitrary.
    localparam logic [23:0] CHIP_ID_DEFAULT = 24'h00_1234;

    localparam logic [15:0] ENABLE_RESET = 16'hFE9B;

    localparam int STB_REGS_RST = 0;
    localparam int STB_DIG_RST  = 1;
    localparam int STB_RESYNC   = 2;
    localparam int STB_TEMP     = 3;

    localparam int EN_OSC_BUF     = 0;
    localparam int EN_BIAS        = 1;
    localparam int EN_REFDIV      = 2;
    localparam int EN_XREF_DIG    = 3;
    localparam int EN_DIVREF_DIG  = 4;
    localparam int EN_SQ_DIG      = 5;
    localparam int EN_SIN_DIG     = 6;
    localparam int EN_SQ_BUF      = 7;
    localparam int EN_SIN_BUF     = 8;
    localparam int EN_MOD_CLK_OSC = 9;
    localparam int EN_PRESC       = 10;
    localparam int EN_LOCK_GATES  = 11;
    localparam int EN_CP          = 12;
    localparam int EN_MOD_RUN     = 13;
    localparam int EN_LOCK_RUN    = 14;
    localparam int EN_SLIP        = 15;

    typedef enum logic [2:0] {
        PER_IDLE,
        PER_ADDR,
        PER_WRITE,
        PER_READ,
        PER_DONE
    } per_state_t;

    typedef struct packed {
        logic osc_buf_on;
        logic bias_on;
        logic refdiv_run;
        logic xref_to_dig;
        logic divref_to_dig;
        logic sq_xtal_to_dig;
        logic sin_xtal_to_dig;
        logic square_ref_buffer_on;
        logic sine_ref_buffer_on;
        logic mod_clk_from_osc;
        logic prescaler_on;
        logic lock_gates_run;
        logic charge_pump_on;
        logic modulator_run;
        logic lock_detect_run;
        logic cycle_slip_prevention;
    } per_ctrl_t;

    typedef struct packed {
        logic regs_soft_reset;
        logic dig_soft_reset;
        logic resync;
        logic temp_measure;
    } per_strobe_t;

endpackage
